// file: design/wst_supervision_timer.sv
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
module wst_supervision_timer
	import wst_pkg::*;
#(
	parameter int TICK_DIVIDE = wst_pkg::TICK_DIV
)(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Fuses, sampled after reset release
	input  wire logic [3:0]  fuseTimeoutSel,
	input  wire logic [3:0]  fuseClosedSel,
	input  wire logic        fuseEnable,
	input  wire logic        fuseWindowEn,
	input  wire logic        fuseLock,
	// Processor event and low-power oscillator tick
	input  wire logic        timerRestartInstruction,
	input  wire logic        lowPowerRefOscTick,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// System reset request
	output logic             systemResetReq
);
	import wst_pkg::*;

	// ==========================================================
	// Tick input synchroniser and edge
	logic tickMeta_r, tickSync_r, tickPrev_r;
	wire  tickEdge = tickSync_r & ~tickPrev_r;
	logic [15:0] divCnt_r;
	wire  divTick = (divCnt_r == 16'(TICK_DIVIDE - 1));
	logic useDivider_r;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tickMeta_r <= 1'b0;
			tickSync_r <= 1'b0;
			tickPrev_r <= 1'b0;
			divCnt_r   <= 16'h0000;
		end
		else
		begin
			tickMeta_r <= lowPowerRefOscTick;
			tickSync_r <= tickMeta_r;
			tickPrev_r <= tickSync_r;
			divCnt_r   <= divTick ? 16'h0000 : divCnt_r + 16'h0001;
		end
	end

	// External oscillator edge drives the count once seen; the divider is a stand-in until then
	wire tick = useDivider_r ? divTick : tickEdge;

	// ==========================================================
	// Restart instruction synchroniser
	logic rstMeta_r, rstSync_r, rstPrev_r;
	wire  restartPulse = rstSync_r & ~rstPrev_r;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
			rstPrev_r <= 1'b0;
		end
		else
		begin
			rstMeta_r <= timerRestartInstruction;
			rstSync_r <= rstMeta_r;
			rstPrev_r <= rstSync_r;
		end
	end

	// ==========================================================
	// Bus address phase capture
	logic       dWrite_r, dRead_r;
	logic [7:0] dAddr_r;
	wire  addrValid = hsel & hready & htrans[1];

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dWrite_r <= 1'b0;
			dRead_r  <= 1'b0;
			dAddr_r  <= 8'h00;
		end
		else if (hready)
		begin
			dWrite_r <= addrValid & hwrite;
			dRead_r  <= addrValid & ~hwrite;
			dAddr_r  <= haddr[7:0];
		end
	end

	// ==========================================================
	// Timed unlock: key write opens a short window
	logic [2:0] unlockCnt_r;
	wire  unlocked   = (unlockCnt_r != 3'h0);
	wire  wrUnlock   = dWrite_r & (dAddr_r == ADDR_UNLOCK) & (hwdata[7:0] == UNLOCK_KEY);
	wire  wrCtrl     = dWrite_r & (dAddr_r == ADDR_CTRL);
	wire  wrWin      = dWrite_r & (dAddr_r == ADDR_WINCTRL);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			unlockCnt_r <= 3'h0;
		else if (wrUnlock)
			unlockCnt_r <= 3'(UNLOCK_CYCLES);
		else if (wrCtrl | wrWin)
			unlockCnt_r <= 3'h0;
		else if (unlocked)
			unlockCnt_r <= unlockCnt_r - 3'h1;
	end

	// ==========================================================
	// Fuse synchroniser
	// Fuses are pins: two flops before the load, so a level still settling at release is never half caught
	logic [10:0] fuseMeta_r, fuseSync_r;
	logic [1:0]  fuseWait_r;
	wire  [10:0] fuseRaw   = {fuseLock, fuseWindowEn, fuseEnable, fuseClosedSel, fuseTimeoutSel};
	wire         fuseReady = (fuseWait_r == 2'h2);
	wire  [3:0]  fuseTs    = fuseSync_r[3:0];
	wire  [3:0]  fuseCs    = fuseSync_r[7:4];
	wire         fuseEn    = fuseSync_r[8];
	wire         fuseWin   = fuseSync_r[9];
	wire         fuseLk    = fuseSync_r[10];

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fuseMeta_r <= 11'h000;
			fuseSync_r <= 11'h000;
			fuseWait_r <= 2'h0;
		end
		else
		begin
			fuseMeta_r <= fuseRaw;
			fuseSync_r <= fuseMeta_r;
			if (!fuseReady)
				fuseWait_r <= fuseWait_r + 2'h1;
		end
	end

	// ==========================================================
	// Configuration registers
	logic       fuseLoad_r;
	logic       lock_r;
	logic [3:0] timeoutSelect_r, closedPeriodSelect_r;
	logic       enable_r, windowEn_r;

	wire ctrlAccept = wrCtrl & unlocked & hwdata[CHG_BIT] & ~lock_r;
	wire winAccept  = wrWin & unlocked & hwdata[CHG_BIT];
	wire [3:0] wrSel = hwdata[SEL_MSB:SEL_LSB];

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fuseLoad_r           <= 1'b1;
			lock_r               <= 1'b0;
			timeoutSelect_r      <= 4'h0;
			closedPeriodSelect_r <= 4'h0;
			enable_r             <= 1'b0;
			windowEn_r           <= 1'b0;
			useDivider_r         <= 1'b1;
		end
		else if (fuseLoad_r)
		begin
			// Writes are ignored until the synchronised fuses have been taken
			if (fuseReady)
			begin
				fuseLoad_r           <= 1'b0;
				lock_r               <= fuseLk;
				timeoutSelect_r      <= fuseTs;
				closedPeriodSelect_r <= fuseCs;
				enable_r             <= fuseEn | fuseLk;
				windowEn_r           <= fuseWin;
			end
		end
		else
		begin
			if (tickEdge)
				useDivider_r <= 1'b0;
			if (ctrlAccept)
			begin
				timeoutSelect_r <= wrSel;
				enable_r        <= hwdata[EN_BIT];
			end
			if (winAccept)
			begin
				if (!lock_r)
					closedPeriodSelect_r <= wrSel;
				windowEn_r <= hwdata[EN_BIT];
			end
		end
	end

	// ==========================================================
	// Sync pending status
	logic [1:0] syncCnt_r;
	wire  syncPending = (syncCnt_r != 2'h0);

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			syncCnt_r <= 2'h0;
		else if ((ctrlAccept | winAccept) & (enable_r | (ctrlAccept & hwdata[EN_BIT])))
			syncCnt_r <= 2'(SYNC_CYCLES);
		else if (syncPending)
			syncCnt_r <= syncCnt_r - 2'h1;
	end

	// ==========================================================
	// Period length: reserved codes clamp to longest
	function automatic logic [CNT_W-1:0] periodTicks(input logic [3:0] code);
		logic [3:0] c;
		c = (code > SEL_MAX_CODE) ? SEL_MAX_CODE : code;
		periodTicks = CNT_W'(14'h0008 << c);
	endfunction

	wire [CNT_W-1:0] openLen   = periodTicks(timeoutSelect_r);
	wire [CNT_W-1:0] closedLen = periodTicks(closedPeriodSelect_r);

	// ==========================================================
	// Supervision counter
	wst_phase_e     phase_r;
	logic [CNT_W-1:0] cnt_r;
	logic           fire_r;
	wst_phase_e     startPhase;
	assign startPhase = windowEn_r ? WST_CLOSED : WST_OPEN;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase_r <= WST_OFF;
			cnt_r   <= '0;
			fire_r  <= 1'b0;
		end
		else
		begin
			fire_r <= 1'b0;
			case (phase_r)
				WST_OFF:
				begin
					cnt_r <= '0;
					if (enable_r & ~fuseLoad_r)
						phase_r <= wst_phase_e'(startPhase);
				end
				WST_CLOSED:
				begin
					if (!enable_r)
						phase_r <= WST_OFF;
					else if (restartPulse)
						fire_r <= 1'b1;
					else if (tick)
					begin
						if (cnt_r == closedLen - 1'b1)
						begin
							cnt_r   <= '0;
							phase_r <= WST_OPEN;
						end
						else
							cnt_r <= cnt_r + 1'b1;
					end
				end
				WST_OPEN:
				begin
					if (!enable_r)
						phase_r <= WST_OFF;
					else if (restartPulse)
					begin
						cnt_r   <= '0;
						phase_r <= wst_phase_e'(startPhase);
					end
					else if (tick)
					begin
						if (cnt_r == openLen - 1'b1)
							fire_r <= 1'b1;
						else
							cnt_r <= cnt_r + 1'b1;
					end
				end
				default:
					phase_r <= WST_OFF;
			endcase
		end
	end

	// Request is held until the system reset it causes clears us
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			systemResetReq <= 1'b0;
		else if (fire_r)
			systemResetReq <= 1'b1;
	end

	// ==========================================================
	// Read data
	wire [31:0] ctrlWord = {26'h0, timeoutSelect_r, enable_r, 1'b0};
	wire [31:0] winWord  = {26'h0, closedPeriodSelect_r, windowEn_r, 1'b0};
	wire [31:0] statWord = {31'h0, syncPending};
	wire [31:0] rdMux    = (haddr[7:0] == ADDR_CTRL)    ? ctrlWord :
	                       (haddr[7:0] == ADDR_WINCTRL) ? winWord  :
	                       (haddr[7:0] == ADDR_STATUS)  ? statWord : 32'h0000_0000;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else if (addrValid & ~hwrite)
			hrdata <= rdMux;
	end

endmodule

// file: design/wst_pkg.sv
package wst_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_WINCTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_UNLOCK  = 8'h0C;

	// ==========================================================
	// Field positions
	localparam int CHG_BIT     = 0;
	localparam int EN_BIT      = 1;
	localparam int SEL_LSB     = 2;
	localparam int SEL_MSB     = 5;
	localparam int SYNC_BIT    = 0;

	// ==========================================================
	// Codes and unlock timing
	localparam logic [3:0]  SEL_MAX_CODE = 4'hA;
	localparam logic [7:0]  UNLOCK_KEY   = 8'hD8;
	localparam int          UNLOCK_CYCLES = 4;

	// ==========================================================
	// Timing
	localparam int CLK_HZ       = 10_000_000;
	localparam int TICK_HZ      = 1_000;
	localparam int TICK_DIV     = CLK_HZ / TICK_HZ;
	localparam int SYNC_CYCLES  = 3;
	localparam int CNT_W        = 14;

	typedef enum logic [1:0] {
		WST_OFF,
		WST_CLOSED,
		WST_OPEN
	} wst_phase_e;

endpackage

// file: bench/wst_supervision_timer_props.sv
`timescale 1ns/10ps
module wst_supervision_timer_props
	import wst_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Reset request
	input wire logic        systemResetReq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire rdReq = hsel && hready && htrans[1] && !hwrite;

	// ====
	// Bus answers
	ready_always_a: assert property (hreadyout) else $error("wait state seen");
	resp_okay_a: assert property (!hresp) else $error("error response seen");
	unmapped_zero_a: assert property (rdReq && haddr == 32'h10 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	status_rsvd_a: assert property (rdReq && haddr == {24'h0, ADDR_STATUS} |=> hrdata[31:1] == '0)
		else $error("status reserved bits set");
	ctrl_chg_a: assert property (rdReq && haddr == {24'h0, ADDR_CTRL} |=> hrdata[31:6] == '0 && !hrdata[0])
		else $error("control readback malformed");
	winctrl_rsvd_a: assert property (rdReq && haddr == {24'h0, ADDR_WINCTRL} |=> hrdata[31:6] == '0)
		else $error("window readback malformed");
	rdata_hold_a: assert property (!rdReq |=> $stable(hrdata)) else $error("read data moved");
	// Request must hold until the next system reset
	reset_sticky_a: assert property (systemResetReq |=> systemResetReq) else $error("reset dropped");
endmodule

bind wst_supervision_timer wst_supervision_timer_props chk (.core_clk, .sys_rst, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .hreadyout, .hresp, .systemResetReq);

// file: bench/wst_supervision_timer_test.sv
`timescale 1ns/10ps
module wst_supervision_timer_test;
	import wst_pkg::*;
	logic        core_clk = 0, sys_rst = 1, restartIn = 0, hwrite = 0;
	logic [3:0]  fTs = 0, fCs = 0;
	logic        fEn = 0, fWin = 0, fLock = 0;
	logic        oscOn = 0;
	logic [2:0]  oscDiv = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
	logic [1:0]  htrans = 0;
	logic        hreadyout, hresp, systemResetReq;
	int          err_total = 0, checks = 0;
	logic [7:0]  rowAddr [5] = '{ADDR_CTRL, ADDR_WINCTRL, ADDR_STATUS, ADDR_UNLOCK, 8'h10};
	logic [31:0] rowExp [5] = '{32'h0C, 32'h08, 32'h0, 32'h0, 32'h0};

	always #50 core_clk = ~core_clk;

	// Oscillator stand-in: one rising edge every 8 cycles once started
	always @(posedge core_clk) oscDiv <= oscOn ? oscDiv + 3'h1 : 3'h0;

	// Small divider keeps every period short; expectations scale by 10, except the oscillator run, which scales by 8
	wst_supervision_timer #(.TICK_DIVIDE(10)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.fuseTimeoutSel(fTs), .fuseClosedSel(fCs), .fuseEnable(fEn), .fuseWindowEn(fWin),
		.fuseLock(fLock), .timerRestartInstruction(restartIn), .lowPowerRefOscTick(oscDiv[2]),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .systemResetReq(systemResetReq));

	// ====
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task uw(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, ADDR_UNLOCK, {24'h0, UNLOCK_KEY});
		bus(1'b1, a, d);
	endtask

	// Change bit of the window register is not defined on readback
	task rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(a == ADDR_WINCTRL ? rdv & 32'hFFFF_FFFE : rdv, e);
	endtask

	task pulse;
		restartIn <= 1'b1;
		@(posedge core_clk);
		restartIn <= 1'b0;
		@(posedge core_clk);
	endtask

	task boot(input logic [3:0] ts, input logic [3:0] cs, input logic en, input logic win, input logic lk);
		{fTs, fCs, fEn, fWin, fLock} <= {ts, cs, en, win, lk};
		sys_rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		// Fuses pass a synchroniser before they load
		repeat (4) @(posedge core_clk);
	endtask

	task expRst(input int lo, input int hi);
		int n;
		n = 0;
		while (systemResetReq !== 1'b1 && n < hi)
		begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(n >= lo && n < hi), 32'h1);
	endtask

	task final_report;
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#4_000_000;
		err_total++;
		final_report;
	end

	// ====
	// Sequence
	initial
	begin
		boot(4'h3, 4'h2, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++)
			rc(rowAddr[i], rowExp[i]);
		pulse;
		repeat (200) @(posedge core_clk);
		chk({31'h0, systemResetReq}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h03);
		rc(ADDR_CTRL, 32'h0C);
		uw(ADDR_CTRL, 32'h02);
		rc(ADDR_CTRL, 32'h0C);
		for (int c = 0; c <= 10; c++)
		begin
			uw(ADDR_CTRL, 32'(c << 2) | 32'h1);
			rc(ADDR_CTRL, 32'(c << 2));
		end
		rc(ADDR_STATUS, 32'h0);
		uw(ADDR_CTRL, 32'h03);
		rc(ADDR_STATUS, 32'h1);
		repeat (6)
		begin
			repeat (48) @(posedge core_clk);
			pulse;
		end
		chk({31'h0, systemResetReq}, 32'h0);
		expRst(70, 100);
		boot(4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
		repeat (20) @(posedge core_clk);
		pulse;
		expRst(0, 12);
		boot(4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
		repeat (110) @(posedge core_clk);
		pulse;
		expRst(140, 185);
		boot(4'h3, 4'h2, 1'b0, 1'b0, 1'b1);
		rc(ADDR_CTRL, 32'h0E);
		uw(ADDR_CTRL, 32'h01);
		rc(ADDR_CTRL, 32'h0E);
		uw(ADDR_WINCTRL, 32'h17);
		rc(ADDR_WINCTRL, 32'h0A);
		boot(4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
		oscOn <= 1'b1;
		expRst(56, 76);
		final_report;
	end
endmodule
